//--- hw/rsp_pkg.sv
// constants and carrier types for the reset-synchronous pwm block
package rsp_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_LATCH   = 8'h00;
  localparam logic [7:0] OFF_DIR     = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_IRQF    = 8'h0C;
  localparam logic [7:0] OFF_MASK    = 8'h10;
  localparam logic [7:0] OFF_START   = 8'h14;
  localparam logic [7:0] OFF_BUFSEL  = 8'h18;
  localparam logic [7:0] OFF_COUNTER = 8'h1C;
  localparam logic [7:0] OFF_IEN     = 8'h20;
  localparam logic [7:0] OFF_GR_BASE = 8'h40;

  // general register indices
  localparam logic [2:0] GR_PERIOD   = 3'h0;
  localparam logic [2:0] GR_PH1      = 3'h1;
  localparam logic [2:0] GR_PH2      = 3'h4;
  localparam logic [2:0] GR_PH3      = 3'h5;

  // field positions
  localparam int STAT_PERIOD = 0;
  localparam int STAT_CMP_B  = 1;
  localparam int STAT_CMP_C  = 2;
  localparam int STAT_CMP_D  = 3;
  localparam int STAT_OVF    = 4;
  localparam int IRQF_PEND   = 1;
  localparam int MASK_CH0    = 1;
  localparam int START_RUN0  = 0;
  localparam int IEN_PERIOD  = 0;

  // reset values
  localparam logic [7:0]  LATCH_RST  = 8'h00;
  localparam logic [7:0]  DIR_RST    = 8'hFF;
  localparam logic [7:0]  MASK_RST   = 8'hFF;
  localparam logic [15:0] GR_RST     = 16'hFFFF;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pin bundle: bit 0 toggle, then normal/counter pairs of phases 1..3
  typedef struct packed {
    logic [6:0] level;
    logic [6:0] oe_n;
  } rsp_pins_t;

endpackage : rsp_pkg

//--- hw/rsp_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module rsp_sync (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic [6:0] d,
  output logic      [6:0] q
);
  logic [6:0] meta;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta <= 7'h00;
      q    <= 7'h00;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : rsp_sync

//--- hw/rsp_phase.sv
// one pwm phase: high from period restart until its compare match
`timescale 1ns/1ps
module rsp_phase (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        run,
  input  wire logic        restart,
  input  wire logic [15:0] counter,
  input  wire logic [15:0] compare,
  output logic             normal
);
  wire hit = run && (counter == compare);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      normal <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        normal <= 1'b1;
      end else if (hit) begin
        normal <= 1'b0;
      end
    end
  end

  a_phase_restart: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && restart |=> normal)
    else $error("phase not high after restart");

  a_phase_match: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && hit && !restart |=> !normal)
    else $error("phase not low after compare match");
endmodule : rsp_phase

//--- hw/rsp_pwm_top.sv
// reset-synchronous three-phase pwm timer with axi4-lite registers
//
// How it works
// - period register sets the count at which each pwm cycle ends
// - toggle pin inverts once every pwm period
// - channel-0 second register is phase 1 transition point, pin pair
// - channel-1 first register is phase 2 transition point, pin pair
// - channel-1 second register is phase 3 transition point, pin pair
// - third and fourth registers drive no pins when buffer select is clear; channel 0's set status matches c, d
// - period buffer select set: third register holds next period
// - phase 1 buffer select set: fourth register holds next phase 1 point
// - phase 2 buffer select set: its buffer holds next phase 2 point
// - phase 3 buffer select set: its buffer holds next phase 3 point
// - direction bit 0 enables output buffer, 1 makes pin an input
// - period match flag, status bit 0, sets on counter equal period
// - period match flag clears only by writing 0 after reading it set
// - irq pending flag bit 1 shows pending request, cleared by writing 0
// - mask bit 1 at 0 lets the interrupt through, 1 withholds it
// - counter runs while start bit 0 is 1, stops when 0
// - status holds overflow, matches d c b a; bit 5 never sets, bits 7:6 reserved
`timescale 1ns/1ps
module rsp_pwm_top (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [6:0]        pin_in,
  output rsp_pkg::rsp_pins_t     pins,
  output logic                   channel0_timer_irq
);
  import rsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic logic is_gr(input logic [7:0] a);
    return (a[7:5] == OFF_GR_BASE[7:5]) && (a[1:0] == 2'h0);
  endfunction : is_gr

  function automatic logic is_mapped(input logic [7:0] a);
    return is_gr(a) || (a[7:2] <= OFF_IEN[7:2] && a[1:0] == 2'h0);
  endfunction : is_mapped

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]  latch;
  logic [7:0]  dir;
  logic [5:0]  stat;
  logic [5:0]  armed;
  logic [7:0]  irqf;
  logic [7:0]  mask;
  logic [3:0]  start;
  logic [3:0]  bufsel;
  logic        ien;
  logic [15:0] counter;
  logic [15:0] gr [8];
  logic        toggle;
  logic        aw_full;
  logic        w_full;
  logic [7:0]  waddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [6:0]  pin_sync;
  logic [2:0]  phase;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write and read channels

  wire aw_hs    = s_axi_awvalid && s_axi_awready;
  wire w_hs     = s_axi_wvalid && s_axi_wready;
  wire ar_hs    = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_full && w_full && !s_axi_bvalid;
  wire next_aw_full = (aw_full || aw_hs) && !do_write;
  wire next_w_full  = (w_full || w_hs) && !do_write;
  wire next_bvalid  = (s_axi_bvalid && !s_axi_bready) || do_write;
  wire next_rvalid  = (s_axi_rvalid && !s_axi_rready) || ar_hs;

  wire wr_b0 = do_write && wstrb[0];
  wire wr_latch  = wr_b0 && waddr == OFF_LATCH;
  wire wr_dir    = wr_b0 && waddr == OFF_DIR;
  wire wr_stat   = wr_b0 && waddr == OFF_STATUS;
  wire wr_irqf   = wr_b0 && waddr == OFF_IRQF;
  wire wr_mask   = wr_b0 && waddr == OFF_MASK;
  wire wr_start  = wr_b0 && waddr == OFF_START;
  wire wr_bufsel = wr_b0 && waddr == OFF_BUFSEL;
  wire wr_ien    = wr_b0 && waddr == OFF_IEN;
  wire rd_stat   = ar_hs && s_axi_araddr == OFF_STATUS;
  wire [7:0] gr_we = (do_write && is_gr(waddr)) ?
                     8'(8'h01 << waddr[4:2]) : 8'h00;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      waddr         <= 8'h00;
      wdata         <= 32'h0000_0000;
      wstrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (ce) begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= !next_aw_full && !next_bvalid;
      s_axi_wready  <= !next_w_full && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (aw_hs) begin
        waddr <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata <= s_axi_wdata;
        wstrb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= is_mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  logic [31:0] rd_value;
  wire  [7:0]  latch_view = (latch & ~dir) | ({1'b0, pin_sync} & dir);

  always_comb begin
    rd_value = 32'h0000_0000;
    if (is_gr(s_axi_araddr)) begin
      rd_value = {16'h0000, gr[s_axi_araddr[4:2]]};
    end else begin
      case (s_axi_araddr)
        OFF_LATCH:   rd_value = {24'h000000, latch_view};
        OFF_DIR:     rd_value = {24'h000000, dir};
        OFF_STATUS:  rd_value = {26'h0, stat};
        OFF_IRQF:    rd_value = {24'h000000, irqf};
        OFF_MASK:    rd_value = {24'h000000, mask};
        OFF_START:   rd_value = {28'h0000000, start};
        OFF_BUFSEL:  rd_value = {28'h0000000, bufsel};
        OFF_COUNTER: rd_value = {16'h0000, counter};
        OFF_IEN:     rd_value = {31'h0, ien};
        default:     rd_value = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= !next_rvalid;
      if (ar_hs) begin
        s_axi_rdata <= rd_value;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter and compare matches

  wire run0         = start[START_RUN0];
  wire period_match = run0 && counter == gr[GR_PERIOD];
  wire [5:0] stat_set = {1'b0,
                         run0 && counter == 16'hFFFF && !period_match,
                         run0 && counter == gr[3],
                         run0 && counter == gr[2],
                         run0 && counter == gr[GR_PH1],
                         period_match};
  wire [5:0] stat_clr = (wr_stat) ? (armed & ~wdata[5:0]) : 6'h00;
  wire irq_set = period_match && ien;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      counter <= 16'h0000;
      toggle  <= 1'b0;
    end else if (ce && run0) begin
      if (period_match) begin
        counter <= 16'h0000;
        toggle  <= !toggle;
      end else begin
        counter <= counter + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // general registers and buffer transfer

  // buffers at indices 2,3,6,7 feed 0,1,4,5 two places below
  wire [7:0] xfer_hit = {2'b00,
                         period_match && bufsel[3],
                         period_match && bufsel[2],
                         2'b00,
                         period_match && bufsel[1],
                         period_match && bufsel[0]};

  for (genvar i = 0; i < 8; i++) begin : g_gr
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        gr[i] <= GR_RST;
      end else if (ce) begin
        if (xfer_hit[i]) begin
          gr[i] <= gr[(i + 2) % 8];
        end else if (gr_we[i]) begin
          gr[i] <= merge16(gr[i], wdata, wstrb);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control, status and interrupt registers

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      latch  <= LATCH_RST;
      dir    <= DIR_RST;
      mask   <= MASK_RST;
      start  <= 4'h0;
      bufsel <= 4'h0;
      ien    <= 1'b0;
      stat   <= 6'h00;
      armed  <= 6'h00;
      irqf   <= 8'h00;
    end else if (ce) begin
      if (wr_latch) latch <= wdata[7:0];
      if (wr_dir) dir <= wdata[7:0];
      if (wr_mask) mask <= wdata[7:0];
      if (wr_start) start <= wdata[3:0];
      if (wr_bufsel) bufsel <= wdata[3:0];
      if (wr_ien) ien <= wdata[IEN_PERIOD];
      stat <= (stat & ~stat_clr) | stat_set;
      if (rd_stat) begin
        armed <= armed | stat;
      end else if (wr_stat) begin
        armed <= 6'h00;
      end
      if (wr_irqf) begin
        irqf <= wdata[7:0] | {6'h00, irq_set, 1'b0};
      end else if (irq_set) begin
        irqf[IRQF_PEND] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      channel0_timer_irq <= 1'b0;
    end else if (ce) begin
      channel0_timer_irq <= irqf[IRQF_PEND] && !mask[MASK_CH0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phases and pins

  localparam logic [2:0] PH_IDX [3] = '{GR_PH1, GR_PH2, GR_PH3};

  for (genvar p = 0; p < 3; p++) begin : g_phase
    rsp_phase u_phase (
      .clock   (clock),
      .rst_n   (rst_n),
      .ce      (ce),
      .run     (run0),
      .restart (period_match),
      .counter (counter),
      .compare (gr[PH_IDX[p]]),
      .normal  (phase[p])
    );
  end

  rsp_sync u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .d     (pin_in),
    .q     (pin_sync)
  );

  wire [6:0] pwm_level = {!phase[2], phase[2], !phase[1], phase[1],
                          !phase[0], phase[0], toggle};
  wire [6:0] next_level = run0 ? pwm_level : latch[6:0];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pins.level <= 7'h00;
      pins.oe_n  <= DIR_RST[6:0];
    end else if (ce) begin
      pins.level <= next_level;
      pins.oe_n  <= dir[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_counter_restart: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && period_match |=> counter == 16'h0000)
    else $error("counter did not restart on period match");

  a_counter_step: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && run0 && !period_match |=> counter == $past(counter) + 16'h0001)
    else $error("counter did not advance");

  a_counter_stopped: assert property (
    @(posedge clock) disable iff (!rst_n)
    !run0 |=> counter == $past(counter))
    else $error("counter moved while stopped");

  a_toggle_flip: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && period_match |=> toggle != $past(toggle))
    else $error("toggle pin did not invert");

  a_period_flag: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && period_match |=> stat[STAT_PERIOD])
    else $error("period flag not set");

  a_flag_clear_read: assert property (
    @(posedge clock) disable iff (!rst_n)
    $fell(stat[STAT_PERIOD]) |-> $past(armed[STAT_PERIOD] && wr_stat))
    else $error("period flag cleared without prior read");

  a_period_buffer: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && period_match && bufsel[0] |=> gr[0] == $past(gr[2]))
    else $error("period buffer not transferred");

  a_irq_pending: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && irq_set |=> irqf[IRQF_PEND])
    else $error("irq pending not raised");

  a_irq_mask: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && mask[MASK_CH0] |=> !channel0_timer_irq)
    else $error("masked interrupt reached output");

  a_counter_phase: assert property (
    @(posedge clock) disable iff (!rst_n)
    $past(ce && run0) |-> pins.level[2] == !pins.level[1] &&
                          pins.level[4] == !pins.level[3] &&
                          pins.level[6] == !pins.level[5])
    else $error("counter-phase pin not complement");

  a_pin_dir: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce ##1 1'b1 |-> pins.oe_n == $past(dir[6:0]))
    else $error("output enable does not follow direction");

  a_write_resp: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && do_write |=> s_axi_bvalid)
    else $error("write response missing");
endmodule : rsp_pwm_top

//--- bench/rsp_stage.sv
// power-stage model: reads driven pins, drives released ones
`timescale 1ns/1ps
module rsp_stage (
  input  wire rsp_pkg::rsp_pins_t pins,
  input  wire logic [6:0]         ext,
  output logic      [6:0]         pin_in
);
  import rsp_pkg::*;
  // a pin shows our drive while enabled, the stage level once released
  assign pin_in = (pins.level & ~pins.oe_n) | (ext & pins.oe_n);
endmodule : rsp_stage

//--- bench/rsp_pwm_top_tb.sv
// self-checking bench for the reset-synchronous pwm block
`timescale 1ns/1ps
module rsp_pwm_top_tb;
  import rsp_pkg::*;
  localparam logic [31:0] FULL = 32'hFFFFFFFF;
  localparam logic [2:0] DIR_IDX [3] = '{GR_PH1, GR_PH2, GR_PH3};
  localparam logic [2:0] BUF_IDX [3] = '{3'h3, 3'h6, 3'h7};
  logic        clock, rst_n;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata, rd_d, r, v;
  logic [1:0]  bresp, rresp, rd_r;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [6:0]  pin_in, ext;
  rsp_pins_t   pins;
  int          n_errors, checks, cyc, per;
  int          hi [3];
  logic [15:0] p, q;
  logic [15:0] c [3];
  logic [15:0] d [3];

  rsp_pwm_top rsp_pwm_top_i (
    .clock(clock), .rst_n(rst_n), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
    .pins(pins), .channel0_timer_irq(irq));
  rsp_stage rsp_stage_i (.pins(pins), .ext(ext), .pin_in(pin_in));

  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] dv,
                    input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr  <= a;
    wdata   <= dv;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clock);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge clock);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [1:0] er,
                    input logic [31:0] m, input logic [31:0] e);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    chk({30'h0, rd_r}, {30'h0, er});
    chk(rd_d & m, e);
    @(posedge clock);
  endtask : rc

  task automatic grw(input logic [2:0] idx, input logic [15:0] gv);
    wr(OFF_GR_BASE + {3'h0, idx, 2'b00}, {16'h0, gv}, RESP_OKAY);
  endtask : grw

  function automatic logic [31:0] exp_hi(logic [15:0] cv, logic [15:0] pp);
    return (cv >= pp) ? pp + 32'h1 : cv + 32'h1;
  endfunction : exp_hi

  ////////////////////////////////////////////////////////////////////////
  // one full period between toggles, counting high cycles per phase
  task automatic pwm_chk(input logic [15:0] pp, input logic [15:0] cv [3]);
    logic t;
    int   n;
    n = 0;
    t = pins.level[0];
    while (pins.level[0] === t && n < 4000) begin
      @(posedge clock);
      n++;
    end
    t = pins.level[0];
    per = 0;
    hi = '{0, 0, 0};
    while (pins.level[0] === t && per < 4000) begin
      for (int k = 0; k < 3; k++) begin
        hi[k] += int'(pins.level[2*k+1]);
        chk({31'h0, pins.level[2*k+2]}, {31'h0, ~pins.level[2*k+1]});
      end
      per++;
      @(posedge clock);
    end
    chk(per, pp + 32'h1);
    for (int k = 0; k < 3; k++) begin
      chk(hi[k], exp_hi(cv[k], pp));
    end
  endtask : pwm_chk

  ////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    checks   = 0;
    cyc      = 0;
    rst_n    = 1'b0;
    awaddr   = 8'h00;
    araddr   = 8'h00;
    awvalid  = 1'b0;
    wvalid   = 1'b0;
    bready   = 1'b0;
    arvalid  = 1'b0;
    rready   = 1'b0;
    wdata    = 32'h0;
    ext      = 7'h55;
    void'($urandom(32'hA8DD));
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    chk({25'h0, pins.oe_n}, 32'h7F);
    chk({31'h0, irq}, 32'h0);
    rc(OFF_DIR, RESP_OKAY, FULL, 32'hFF);
    rc(OFF_MASK, RESP_OKAY, FULL, 32'hFF);
    rc(8'h3C, RESP_SLVERR, FULL, 32'h0);
    wr(8'h24, 32'h1, RESP_SLVERR);
    wr(OFF_START + 8'h01, 32'h1, RESP_SLVERR);
    // latch and direction with the counter idle
    r = $urandom;
    wr(OFF_DIR, 32'h0, RESP_OKAY);
    wr(OFF_LATCH, r, RESP_OKAY);
    repeat (2) @(posedge clock);
    chk({25'h0, pins.level}, {25'h0, r[6:0]});
    chk({25'h0, pins.oe_n}, 32'h0);
    ext <= 7'($urandom);
    wr(OFF_DIR, 32'h7F, RESP_OKAY);
    repeat (4) @(posedge clock);
    chk({25'h0, pins.oe_n}, 32'h7F);
    rc(OFF_LATCH, RESP_OKAY, 32'hFF, {24'h0, r[7], ext});
    wr(OFF_DIR, 32'h0, RESP_OKAY);
    // direct registers, with a tie and a zero compare among them
    p = 16'h000C + 16'($urandom % 20);
    c = '{p, 16'h0, 16'($urandom % p)};
    grw(GR_PERIOD, p);
    for (int k = 0; k < 3; k++) grw(DIR_IDX[k], c[k]);
    wr(OFF_BUFSEL, 32'h0, RESP_OKAY);
    wr(OFF_IEN, 32'h1, RESP_OKAY);
    wr(OFF_MASK, 32'hFD, RESP_OKAY);
    wr(OFF_START, 32'h1, RESP_OKAY);
    pwm_chk(p, c);
    chk({31'h0, irq}, 32'h1);
    rc(OFF_IRQF, RESP_OKAY, 32'h2, 32'h2);
    // buffers ignored while not selected, loaded at restart once selected
    q = p + 16'h0005;
    d = '{16'($urandom % q), q - 16'h1, 16'($urandom % q)};
    grw(3'h2, q);
    for (int k = 0; k < 3; k++) grw(BUF_IDX[k], d[k]);
    pwm_chk(p, c);
    wr(OFF_BUFSEL, 32'hF, RESP_OKAY);
    pwm_chk(q, d);
    // stop and freeze
    wr(OFF_START, 32'h0, RESP_OKAY);
    grw(GR_PERIOD, 16'hFFFF);
    grw(3'h2, 16'hFFFF);
    rc(OFF_COUNTER, RESP_OKAY, 32'h0, 32'h0);
    v = rd_d;
    chk({31'h0, v[15:0] <= q}, 32'h1);
    repeat (5) @(posedge clock);
    rc(OFF_COUNTER, RESP_OKAY, FULL, v);
    // status flag clears only after it was read set
    wr(OFF_STATUS, 32'h0, RESP_OKAY);
    rc(OFF_STATUS, RESP_OKAY, 32'hC1, 32'h01);
    wr(OFF_STATUS, 32'h0, RESP_OKAY);
    rc(OFF_STATUS, RESP_OKAY, 32'h1, 32'h0);
    // mask and pending flag
    wr(OFF_MASK, 32'hFF, RESP_OKAY);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_MASK, 32'hFD, RESP_OKAY);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQF, 32'h0, RESP_OKAY);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    rc(OFF_IRQF, RESP_OKAY, 32'h2, 32'h0);
    summarize();
  end
endmodule : rsp_pwm_top_tb
